// [fbs_pkg.sv]
// Purpose: shared constants, state codes and burst arithmetic of the burst sram port
// Assumes: one 100 MHz clock, four byte lanes with one parity bit each
// Notes: counts derived from times are computed here, not typed in by hand
`default_nettype none

package fbs_pkg;

    // =========================================================
    // geometry
    localparam int ADDR_W = 18;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int BURST_W = 2;
    localparam int SLOT_W = LANE_W + 1;
    localparam int WORD_W = LANES * SLOT_W;

    // =========================================================
    // reset values
    localparam logic [1:0] BURST_RST = 2'h0;
    localparam logic ORDER_RST = 1'h1;
    localparam logic OE_N_RST = 1'h1;
    localparam logic SLEEP_RST = 1'h0;
    localparam logic [3:0] LANES_ALL = 4'hf;
    localparam logic [3:0] LANES_NONE = 4'h0;

    // =========================================================
    // timing
    localparam int CLK_PERIOD_PS = 10000;
    localparam int CLK_TO_VALID_PS = 6500;
    // longest time rounds down, never below one cycle
    localparam int CLK_TO_VALID_CYC = (CLK_TO_VALID_PS / CLK_PERIOD_PS) < 1 ? 1
                                      : (CLK_TO_VALID_PS / CLK_PERIOD_PS);
    // sleep entry and exit, and master recovery, in clock cycles as printed
    localparam int SLEEP_ENTRY_CYC = 2;
    localparam int SLEEP_RECOVERY_CYC = 2;
    localparam int SYNC_STAGES = SLEEP_ENTRY_CYC;

    // =========================================================
    // access state, one-hot
    typedef enum logic [2:0] {
        ST_DESEL = 3'h1,
        ST_ACTIVE = 3'h2,
        ST_SLEEP = 3'h4
    } fbs_state_t;

    // burst address from start value and step number
    function automatic logic [1:0] burst_addr(input logic [1:0] start, input logic [1:0] seq,
                                              input logic interleave);
        logic [1:0] res;
        res = interleave ? (start ^ seq) : 2'(start + seq);
        return res;
    endfunction

endpackage

`default_nettype wire

// [fbs_sync2.sv]
// Purpose: two-stage synchroniser for pins that arrive outside the clock domain
// Assumes: synchronous active-low reset, clock enable freezes the stages
// Notes: only the second stage may be read by other logic
`timescale 1ns/10ps
`default_nettype none

module fbs_sync2
    import fbs_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    // =========================================================
    // stages
    logic [W-1:0] meta;

    // first stage feeds the second only
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            meta <= RST_VAL;
            o_sync <= RST_VAL;
        end
        else if (i_clk_en)
        begin
            meta <= i_async;
            o_sync <= meta;
        end
    end

endmodule

`default_nettype wire

// [fbs_burst_ctr.sv]
// Purpose: two-bit wraparound burst counter, linear or interleaved
// Assumes: load and step never asserted together
// Notes: keeps start value and step number so both orders share one counter
`timescale 1ns/10ps
`default_nettype none

module fbs_burst_ctr
    import fbs_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_load,
    input wire logic [1:0] i_load_val,
    input wire logic i_step,
    input wire logic i_interleave,
    output logic [1:0] o_cur,
    output logic [1:0] o_next
);

    // =========================================================
    // counter state
    logic [1:0] start;
    logic [1:0] seq;

    // start loaded at burst start, step number moves only on advance
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            start <= BURST_RST;
            seq <= BURST_RST;
        end
        else if (i_clk_en)
        begin
            if (i_load)
            begin
                start <= i_load_val;
                seq <= BURST_RST;
            end
            else if (i_step)
            begin
                seq <= 2'(seq + 2'h1);
            end
        end
    end

    // current and following address, wraps modulo four
    assign o_cur = burst_addr(start, seq, i_interleave);
    assign o_next = burst_addr(start, 2'(seq + 2'h1), i_interleave);

endmodule

`default_nettype wire

// [fbs_sram_port.sv]
// Purpose: synchronous flow-through burst sram with common data pins
// Assumes: bus master runs on i_ref_clk; output enable and sleep pins are asynchronous
// Notes: output enable reaches the pins three cycles late, two in its synchroniser and one in the drive register
//
// How it works
// - every synchronous pin is sampled on the rising clock edge only
// - strap low gives linear order, high or floating gives interleaved order
// - two-bit wrapping counter loads low address bits, four accesses per burst
// - interleaved order xors start with 01, 10, 11
// - linear order adds one to the previous address modulo four
// - processor strobe is ignored while first chip select is high
// - all selects active plus a strobe low starts access, loads address
// - read data appears in the cycle the address is registered
// - processor-strobe start ignores all write controls and reads
// - write at the next edge after processor start stores enabled bytes
// - controller strobe with write controls writes the new address at once
// - any detected write turns the data pins off regardless of enable
// - lane gate plus lane selects pick bytes; global write writes all four
// - writes are timed inside, no write pulse needed from master
// - burst advances only when the advance input asks
// - sleep entered and left within two cycles, contents kept
// - an access pending at sleep entry is dropped
// - write means global write low, or lane gate low with a lane selected
// - with both strobes high, advance low steps, high repeats the address
// - pins off while deselected and on the first clock after leaving it
// - parity bits follow their byte and its lane select
`timescale 1ns/10ps
`default_nettype none

module fbs_sram_port
    import fbs_pkg::*;
#(
    parameter int AW = ADDR_W
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic [AW-1:0] i_addr,
    input wire logic i_chip_sel1_n,
    input wire logic i_chip_sel2,
    input wire logic i_chip_sel3_n,
    input wire logic i_cpu_addr_strobe_n,
    input wire logic i_ctrl_addr_strobe_n,
    input wire logic i_burst_step_n,
    input wire logic i_all_lanes_write_n,
    input wire logic i_lane_write_gate_n,
    input wire logic [LANES-1:0] i_lane_select_n,
    input wire logic i_out_enable_n,
    input wire logic i_sleep_req,
    input wire logic i_burst_order,
    input wire logic [LANES*LANE_W-1:0] i_data,
    output logic [LANES*LANE_W-1:0] o_data,
    output logic o_data_oe,
    input wire logic [LANES-1:0] i_lane_parity_io,
    output logic [LANES-1:0] o_lane_parity_io,
    output logic o_lane_parity_io_oe,
    output logic o_asleep
);

    // =========================================================
    // storage
    localparam int DEPTH = 1 << AW;
    logic [WORD_W-1:0] mem [DEPTH];

    // =========================================================
    // state and synchronised pins
    fbs_state_t state;
    fbs_state_t next_state;
    logic oe_n_sync;
    logic sleep_sync;
    logic order_sync;
    logic interleave;
    logic first_after_desel;
    logic [AW-1:BURST_W] held_high;

    // =========================================================
    // cycle decode
    logic sel_all;
    logic cpu_go;
    logic ctrl_go;
    logic start;
    logic desel;
    logic cont;
    logic step;
    logic wr_req;
    logic [LANES-1:0] wr_lanes;
    logic cur_wr;
    logic cur_rd;
    logic [AW-1:0] used_addr;
    logic [1:0] burst_cur;
    logic [1:0] burst_next;
    logic [WORD_W-1:0] rd_word;

    // =========================================================
    // pin synchronisers
    // output enable is asynchronous; the pins answer it three cycles late
    fbs_sync2 #(
        .W(1),
        .RST_VAL(OE_N_RST)
    ) u_oe_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en),
        .i_async(i_out_enable_n),
        .o_sync(oe_n_sync)
    );

    // sleep request: the two stages are the entry delay
    fbs_sync2 #(
        .W(1),
        .RST_VAL(SLEEP_RST)
    ) u_sleep_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en),
        .i_async(i_sleep_req),
        .o_sync(sleep_sync)
    );

    // burst order strap, static pin, default interleaved
    fbs_sync2 #(
        .W(1),
        .RST_VAL(ORDER_RST)
    ) u_order_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en),
        .i_async(i_burst_order),
        .o_sync(order_sync)
    );

    // =========================================================
    // burst order
    // strap follows its synchronised level; a strap should not move in use
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            interleave <= ORDER_RST;
        end
        else if (i_clk_en)
        begin
            interleave <= order_sync;
        end
    end

    // =========================================================
    // burst counter
    fbs_burst_ctr u_burst (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en),
        .i_load(start),
        .i_load_val(i_addr[BURST_W-1:0]),
        .i_step(step),
        .i_interleave(interleave),
        .o_cur(burst_cur),
        .o_next(burst_next)
    );

    // =========================================================
    // access decode, all pins here are taken as sampled at this edge
    always_comb
    begin
        // all three chip selects active
        sel_all = !i_chip_sel1_n && i_chip_sel2 && !i_chip_sel3_n;
        // processor strobe counts only with first select low
        cpu_go = !i_cpu_addr_strobe_n && !i_chip_sel1_n;
        // low processor strobe wins over the controller strobe
        ctrl_go = !i_ctrl_addr_strobe_n && !cpu_go;
        // write lanes: global write forces all, gate qualifies selects
        if (!i_all_lanes_write_n)
        begin
            wr_lanes = LANES_ALL;
        end
        else if (!i_lane_write_gate_n)
        begin
            wr_lanes = ~i_lane_select_n;
        end
        else
        begin
            wr_lanes = LANES_NONE;
        end
        wr_req = |wr_lanes;
        start = 1'b0;
        desel = 1'b0;
        cont = 1'b0;
        if (state != ST_SLEEP && !sleep_sync)
        begin
            if (cpu_go || ctrl_go)
            begin
                start = sel_all;
                desel = !sel_all;
            end
            else
            begin
                // both strobes idle, burst goes on if one is open
                cont = (state == ST_ACTIVE);
            end
        end
        // advance steps, otherwise the address repeats
        step = cont && !i_burst_step_n;
        // a processor-strobe start is always a read
        cur_wr = (start && ctrl_go && wr_req) || (cont && wr_req);
        cur_rd = (start && !cur_wr) || (cont && !wr_req);
        // address used this cycle
        if (start)
        begin
            used_addr = i_addr;
        end
        else if (step)
        begin
            used_addr = {held_high, burst_next};
        end
        else
        begin
            used_addr = {held_high, burst_cur};
        end
        rd_word = mem[used_addr];
    end

    // =========================================================
    // access state machine
    always_comb
    begin
        case (state)
            ST_DESEL:
            begin
                next_state = start ? ST_ACTIVE : ST_DESEL;
            end
            ST_ACTIVE:
            begin
                next_state = desel ? ST_DESEL : ST_ACTIVE;
            end
            ST_SLEEP:
            begin
                // leaving sleep lands deselected
                next_state = sleep_sync ? ST_SLEEP : ST_DESEL;
            end
            default:
            begin
                next_state = ST_DESEL;
            end
        endcase
        // sleep overrides anything pending, which is then lost
        if (sleep_sync)
        begin
            next_state = ST_SLEEP;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            state <= ST_DESEL;
        end
        else if (i_clk_en)
        begin
            state <= next_state;
        end
    end

    // =========================================================
    // upper address bits held for the rest of the burst
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            held_high <= '0;
        end
        else if (i_clk_en && start)
        begin
            held_high <= i_addr[AW-1:BURST_W];
        end
    end

    // =========================================================
    // first clock after deselect keeps pins off
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            first_after_desel <= 1'b1;
        end
        else if (i_clk_en)
        begin
            if (desel || sleep_sync || state == ST_SLEEP)
            begin
                first_after_desel <= 1'b1;
            end
            else if (start)
            begin
                first_after_desel <= 1'b0;
            end
        end
    end

    // =========================================================
    // self-timed write: data pins sampled at the same edge as controls
    // nothing is written once sleep is seen, so contents survive it
    always_ff @(posedge i_ref_clk)
    begin
        if (i_clk_en && cur_wr)
        begin
            for (int i = 0; i < LANES; i++)
            begin
                if (wr_lanes[i])
                begin
                    // parity bit travels with its byte
                    mem[used_addr][i*SLOT_W +: SLOT_W] <= {i_lane_parity_io[i],
                        i_data[i*LANE_W +: LANE_W]};
                end
            end
        end
    end

    // =========================================================
    // read data, registered at the address edge
    // the word read is already on the pins after the edge that took its address
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            o_data <= '0;
            o_lane_parity_io <= '0;
        end
        else if (i_clk_en && cur_rd)
        begin
            for (int i = 0; i < LANES; i++)
            begin
                o_data[i*LANE_W +: LANE_W] <= rd_word[i*SLOT_W +: LANE_W];
                o_lane_parity_io[i] <= rd_word[i*SLOT_W + LANE_W];
            end
        end
    end

    // =========================================================
    // pin drive: reads only, never during a write, deselect or sleep
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            o_data_oe <= 1'b0;
            o_lane_parity_io_oe <= 1'b0;
        end
        else if (i_clk_en)
        begin
            if (cur_wr || !cur_rd)
            begin
                o_data_oe <= 1'b0;
                o_lane_parity_io_oe <= 1'b0;
            end
            else if (start && first_after_desel)
            begin
                o_data_oe <= 1'b0;
                o_lane_parity_io_oe <= 1'b0;
            end
            else
            begin
                o_data_oe <= !oe_n_sync;
                o_lane_parity_io_oe <= !oe_n_sync;
            end
        end
    end

    // =========================================================
    // sleep status pin
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            o_asleep <= SLEEP_RST;
        end
        else if (i_clk_en)
        begin
            o_asleep <= sleep_sync;
        end
    end

endmodule

`default_nettype wire

// [fbs_sram_port_properties.sv]
// Purpose: port-level properties of the burst sram port
// Assumes: clock enable held high, one clock domain
// Notes: output enable is judged only after its synchroniser has settled
`timescale 1ns/10ps
`default_nettype none

module fbs_sram_port_chk
    import fbs_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_chip_sel1_n,
    input wire logic i_chip_sel2,
    input wire logic i_chip_sel3_n,
    input wire logic i_cpu_addr_strobe_n,
    input wire logic i_ctrl_addr_strobe_n,
    input wire logic i_all_lanes_write_n,
    input wire logic i_lane_write_gate_n,
    input wire logic [LANES-1:0] i_lane_select_n,
    input wire logic i_out_enable_n,
    input wire logic i_sleep_req,
    input wire logic o_data_oe,
    input wire logic o_lane_parity_io_oe,
    input wire logic o_asleep
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    // ==========================================================
    // decoded bus cycle
    logic sel;
    logic wr;
    assign sel = !i_chip_sel1_n && i_chip_sel2 && !i_chip_sel3_n;
    assign wr = !i_all_lanes_write_n || (!i_lane_write_gate_n && !(&i_lane_select_n));

    sequence s_desel;
        (!i_ctrl_addr_strobe_n || (!i_cpu_addr_strobe_n && !i_chip_sel1_n)) && !sel && !i_sleep_req;
    endsequence
    sequence s_cpu_go;
        !i_cpu_addr_strobe_n && sel && !i_sleep_req;
    endsequence
    sequence s_hold_rd;
        i_cpu_addr_strobe_n && i_ctrl_addr_strobe_n && !wr && o_data_oe;
    endsequence

    // ==========================================================
    // output drive
    property p_ctrl_wr;
        i_cpu_addr_strobe_n && !i_ctrl_addr_strobe_n && sel && wr |=> !o_data_oe;
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("pins driven after controller write");
    property p_cont_wr;
        i_cpu_addr_strobe_n && i_ctrl_addr_strobe_n && wr |=> !o_data_oe;
    endproperty
    a_cont_wr: assert property (p_cont_wr) else $error("pins driven after burst write");
    property p_desel;
        s_desel |=> !o_data_oe;
    endproperty
    a_desel: assert property (p_desel) else $error("pins driven while deselected");
    property p_first;
        s_desel ##1 s_cpu_go |=> !o_data_oe;
    endproperty
    a_first: assert property (p_first) else $error("pins driven on first cycle after deselect");
    property p_oe_off;
        i_out_enable_n [*3] |=> !o_data_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("pins driven with enable off");
    property p_rd_on;
        (!i_out_enable_n && !i_sleep_req) [*4] ##0 s_hold_rd |=> o_data_oe;
    endproperty
    a_rd_on: assert property (p_rd_on) else $error("read burst lost its drive");
    property p_par;
        o_lane_parity_io_oe == o_data_oe;
    endproperty
    a_par: assert property (p_par) else $error("parity drive differs from data");

    // ==========================================================
    // sleep
    property p_sleep_in;
        i_sleep_req [*2] |-> ##[1:2] o_asleep;
    endproperty
    a_sleep_in: assert property (p_sleep_in) else $error("sleep entry too slow");
    property p_sleep_out;
        (!i_sleep_req) [*2] |-> ##[1:2] !o_asleep;
    endproperty
    a_sleep_out: assert property (p_sleep_out) else $error("sleep exit too slow");
    property p_asleep;
        o_asleep |-> !o_data_oe;
    endproperty
    a_asleep: assert property (p_asleep) else $error("pins driven in sleep");
endmodule

bind fbs_sram_port fbs_sram_port_chk i_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_chip_sel1_n(i_chip_sel1_n), .i_chip_sel2(i_chip_sel2), .i_chip_sel3_n(i_chip_sel3_n),
    .i_cpu_addr_strobe_n(i_cpu_addr_strobe_n), .i_ctrl_addr_strobe_n(i_ctrl_addr_strobe_n),
    .i_all_lanes_write_n(i_all_lanes_write_n), .i_lane_write_gate_n(i_lane_write_gate_n),
    .i_lane_select_n(i_lane_select_n), .i_out_enable_n(i_out_enable_n), .i_sleep_req(i_sleep_req),
    .o_data_oe(o_data_oe), .o_lane_parity_io_oe(o_lane_parity_io_oe), .o_asleep(o_asleep));

`default_nettype wire

// [fbs_host.sv]
// Purpose: bus master model that drives the burst sram port
// Assumes: every request is launched at a rising edge
// Notes: released data lines show the inverse of their last level
`timescale 1ns/10ps
`default_nettype none

module fbs_host
    import fbs_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic [31:0] i_rd,
    input wire logic i_rd_oe,
    output logic [5:0] o_addr,
    output logic [2:0] o_cs,
    output logic o_cpu_n,
    output logic o_ctrl_n,
    output logic o_step_n,
    output logic [5:0] o_wr,
    output logic o_oe_n,
    output logic o_sleep,
    output logic [31:0] o_wd,
    output logic [3:0] o_wp
);
    logic drv = 1'b0;
    logic [31:0] wd = '0;
    logic [31:0] last = '0;
    bit at_edge = 1'b0;

    // ==========================================================
    // shared data lines: ours, the device's, or a shifting leftover
    assign o_wd = drv ? wd : (i_rd_oe ? i_rd : ~last);
    assign o_wp = drv ? wd[31:28] : ~last[31:28];
    // the leftover pattern changes each cycle so a stale value never passes
    always @(posedge i_ref_clk)
        last <= o_wd;

    // bus starts deselected with strobes idle
    initial
    begin
        o_addr = '0;
        o_cs = 3'b100;
        o_cpu_n = 1'b1;
        o_ctrl_n = 1'b1;
        o_step_n = 1'b1;
        o_wr = 6'h3f;
        o_oe_n = 1'b1;
        o_sleep = 1'b0;
    end

    // idle continue cycle: no strobe, no step, no write
    task automatic idle();
        o_cpu_n <= 1'b1;
        o_ctrl_n <= 1'b1;
        o_step_n <= 1'b1;
        o_wr <= 6'h3f;
        drv <= 1'b0;
    endtask

    // one bus cycle; nx keeps the next request back to back
    task automatic op(input logic [2:0] cs, input logic cpu, input logic ctrl, input logic stp,
                      input logic [5:0] wr, input logic [5:0] a, input logic [31:0] d, input bit nx);
        logic w;
        w = (cpu || cs[2]) && (!wr[5] || (!wr[4] && !(&wr[3:0])));
        if (!at_edge)
            @(posedge i_ref_clk);
        // outputs must be off before our data meets the lines
        if (w != o_oe_n)
        begin
            o_oe_n <= w;
            repeat (3) @(posedge i_ref_clk);
        end
        o_cs <= cs;
        o_cpu_n <= cpu;
        o_ctrl_n <= ctrl;
        o_step_n <= stp;
        o_wr <= wr;
        o_addr <= a;
        drv <= w;
        wd <= d;
        @(posedge i_ref_clk);
        at_edge = nx;
        if (!nx)
            idle();
    endtask

    // deselect before sleep, keep quiet while the device wakes
    task automatic doze(input logic v);
        @(posedge i_ref_clk);
        if (v)
        begin
            o_cs <= 3'b000;
            o_ctrl_n <= 1'b0;
            @(posedge i_ref_clk);
            o_ctrl_n <= 1'b1;
        end
        o_sleep <= v;
        if (!v)
            repeat (SLEEP_RECOVERY_CYC + SYNC_STAGES) @(posedge i_ref_clk);
        at_edge = 1'b0;
    endtask
endmodule

`default_nettype wire

// [fbs_sram_port_test.sv]
// Purpose: self-checking bench of the burst sram port
// Assumes: clock enable tied high, six address bits
// Notes: each bus cycle is followed by an idle one unless chained
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; $display("Error at %0t: %h vs %h", $time, (a), (b)); end end

module fbs_sram_port_test
    import fbs_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic order = 1'b1;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] md [64];
    logic [3:0] mp [64];
    wire [5:0] addr;
    wire [2:0] cs;
    wire cpu_n, ctrl_n, step_n, oe_n, sleep, rd_oe, p_oe, asleep;
    wire [5:0] wr;
    wire [31:0] wd, rd;
    wire [3:0] wp, rp;

    fbs_host i_host (.i_ref_clk(clk), .i_rd(rd), .i_rd_oe(rd_oe), .o_addr(addr), .o_cs(cs), .o_cpu_n(cpu_n),
        .o_ctrl_n(ctrl_n), .o_step_n(step_n), .o_wr(wr), .o_oe_n(oe_n), .o_sleep(sleep), .o_wd(wd), .o_wp(wp));
    fbs_sram_port #(.AW(6)) i_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_addr(addr),
        .i_chip_sel1_n(cs[2]), .i_chip_sel2(cs[1]), .i_chip_sel3_n(cs[0]), .i_cpu_addr_strobe_n(cpu_n),
        .i_ctrl_addr_strobe_n(ctrl_n), .i_burst_step_n(step_n), .i_all_lanes_write_n(wr[5]),
        .i_lane_write_gate_n(wr[4]), .i_lane_select_n(wr[3:0]), .i_out_enable_n(oe_n), .i_sleep_req(sleep),
        .i_burst_order(order), .i_data(wd), .o_data(rd), .o_data_oe(rd_oe), .i_lane_parity_io(wp),
        .o_lane_parity_io(rp), .o_lane_parity_io_oe(p_oe), .o_asleep(asleep));

    // ==========================================================
    // clock and hang guard, sized well above the whole run
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    function automatic logic [31:0] pat(input logic [5:0] a);
        return {2'b11, a, 2'b10, a, 2'b01, a, 2'b00, a};
    endfunction

    // expected memory: lane i is byte i plus parity bit i
    task automatic put(input logic [5:0] a, input logic [31:0] d, input logic [3:0] ln);
        for (int i = 0; i < 4; i++)
            if (!ln[i])
            begin
                md[a][8*i +: 8] = d[8*i +: 8];
                mp[a][i] = d[28 + i];
            end
    endtask

    // outputs settle after the edge; judge at the falling edge
    task automatic look(input logic [5:0] a, input logic oe);
        @(negedge clk);
        `CHK({rd_oe, p_oe}, {oe, oe})
        if (oe)
        begin
            `CHK(rd, md[a])
            `CHK(rp, mp[a])
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_fill();
        for (int a = 0; a < 8; a++)
        begin
            i_host.op(3'b010, 1'b1, 1'b0, 1'b1, 6'h1f, 6'(a), pat(6'(a)), 1'b0);
            put(6'(a), pat(6'(a)), 4'h0);
            look(6'(a), 1'b0);
        end
    endtask

    task automatic t_cpu();
        i_host.op(3'b010, 1'b0, 1'b1, 1'b1, 6'h00, 6'h05, 32'h0, 1'b0);
        look(6'h05, 1'b1);
        i_host.op(3'b110, 1'b0, 1'b1, 1'b1, 6'h3f, 6'h02, 32'h0, 1'b0);
        look(6'h05, 1'b1);
    endtask

    // lanes 0 and 2 only, at the address held from the strobe start
    task automatic t_lane();
        i_host.op(3'b010, 1'b0, 1'b1, 1'b1, 6'h3f, 6'h06, 32'h0, 1'b0);
        i_host.op(3'b010, 1'b1, 1'b1, 1'b1, 6'h2a, 6'h00, ~pat(6'h06), 1'b0);
        put(6'h06, ~pat(6'h06), 4'ha);
        look(6'h06, 1'b0);
        i_host.op(3'b010, 1'b0, 1'b1, 1'b1, 6'h3f, 6'h06, 32'h0, 1'b0);
        look(6'h06, 1'b1);
    endtask

    // idle cycles between steps check that the counter holds
    task automatic t_burst(input logic ord, input logic [1:0] st);
        logic [1:0] lo;
        @(posedge clk);
        order <= ord;
        repeat (6) @(posedge clk);
        i_host.op(3'b010, 1'b0, 1'b1, 1'b1, 6'h3f, {4'h1, st}, 32'h0, 1'b0);
        look({4'h1, st}, 1'b1);
        for (int k = 1; k < 6; k++)
        begin
            lo = ord ? (st ^ 2'(k)) : 2'(st + 2'(k));
            i_host.op(3'b010, 1'b1, 1'b1, 1'b0, 6'h3f, 6'h00, 32'h0, 1'b0);
            look({4'h1, lo}, 1'b1);
        end
    endtask

    task automatic t_desel();
        i_host.op(3'b000, 1'b1, 1'b0, 1'b1, 6'h3f, 6'h00, 32'h0, 1'b1);
        i_host.op(3'b010, 1'b0, 1'b1, 1'b1, 6'h3f, 6'h04, 32'h0, 1'b0);
        look(6'h04, 1'b0);
        i_host.op(3'b010, 1'b1, 1'b1, 1'b0, 6'h3f, 6'h00, 32'h0, 1'b0);
        look(6'h05, 1'b1);
    endtask

    task automatic t_sleep();
        i_host.doze(1'b1);
        repeat (4) @(posedge clk);
        @(negedge clk);
        `CHK(asleep, 1'b1)
        `CHK(rd_oe, 1'b0)
        i_host.doze(1'b0);
        @(negedge clk);
        `CHK(asleep, 1'b0)
        i_host.op(3'b010, 1'b1, 1'b0, 1'b1, 6'h3f, 6'h02, 32'h0, 1'b0);
        i_host.op(3'b010, 1'b1, 1'b1, 1'b0, 6'h3f, 6'h00, 32'h0, 1'b0);
        look(6'h03, 1'b1);
    endtask

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // main sequence after the reset hold
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_fill();
        t_cpu();
        t_lane();
        t_burst(1'b1, 2'h1);
        t_burst(1'b0, 2'h2);
        t_desel();
        t_sleep();
        end_of_test();
    end
endmodule

`default_nettype wire
